/* pwmg_map.svh */
/*
  Register map, field positions and reset values of the four-generator PWM control block.
  Assumes a 12-bit APB byte address and 32-bit data, one aligned word per register.
*/
`ifndef PWMG_MAP_SVH
`define PWMG_MAP_SVH

// ============================================================
// Module-level registers
`define PWMG_OFF_SYNC      12'h000
`define PWMG_OFF_MOD_INTEN 12'h004
`define PWMG_OFF_MOD_RIS   12'h008
`define PWMG_OFF_MOD_ISC   12'h00c

// ============================================================
// Generator blocks: block field paddr[8:6] = generator + 1
`define PWMG_BLK_FIRST     3'h1
`define PWMG_BLK_LAST      3'h4
`define PWMG_OFF_GEN_CTL   6'h00
`define PWMG_OFF_GEN_LOAD  6'h04
`define PWMG_OFF_GEN_COUNT 6'h08
`define PWMG_OFF_GEN_CMPA  6'h0c
`define PWMG_OFF_GEN_CMPB  6'h10
`define PWMG_OFF_GEN_INTEN 6'h14
`define PWMG_OFF_GEN_RIS   6'h18
`define PWMG_OFF_GEN_ISC   6'h1c

// ============================================================
// Field positions
`define PWMG_CTL_EN_BIT    0
`define PWMG_CTL_MODE_BIT  1
`define PWMG_CTL_SYNC_BIT  2
`define PWMG_TRIG_LSB      8
`define PWMG_FAULT_LSB     4

// ============================================================
// Reset values
`define PWMG_RST_CTL       3'h0
`define PWMG_RST_VAL16     16'h0000
`define PWMG_RST_INTEN     14'h0000
`define PWMG_RST_MOD_INTEN 8'h00

`endif

/* pwmg_pkg.sv */
/*
  Types shared by the PWM control block files.
  Assumes the map header supplies offsets and field positions.
*/
package pwmg_pkg;

  typedef enum logic [0:0] {
    PWMG_DIR_DOWN = 1'b0,
    PWMG_DIR_UP   = 1'b1
  } pwmg_dir_e;

  typedef struct packed {
    logic sync_mode;
    logic up_down;
    logic enable;
  } pwmg_ctl_s;

  typedef struct packed {
    logic cmp_b_down;
    logic cmp_b_up;
    logic cmp_a_down;
    logic cmp_a_up;
    logic count_reload;
    logic count_at_zero;
  } pwmg_evt_s;

  typedef logic [15:0] pwmg_val_t;

endpackage : pwmg_pkg

/* pwmg_gen.sv */
/*
  One PWM generator: counter, pending period/compare values and event decode.
  Assumes the parent registers the events and holds the register interface.
*/
`timescale 1ns/1ps
`include "pwmg_map.svh"

module pwmg_gen
  import pwmg_pkg::*;
(
  input  wire logic      pclk,
  input  wire logic      presetn,
  input  wire pwmg_ctl_s ctl,
  input  wire logic      sync_evt,
  input  wire logic      load_wr,
  input  wire logic      cmpa_wr,
  input  wire logic      cmpb_wr,
  input  wire pwmg_val_t wdata,
  output pwmg_val_t      load_prog,
  output pwmg_val_t      cmpa_prog,
  output pwmg_val_t      cmpb_prog,
  output pwmg_val_t      count,
  output pwmg_evt_s      evt
);

  pwmg_dir_e dir;
  pwmg_val_t act_load;
  pwmg_val_t act_a;
  pwmg_val_t act_b;
  pwmg_val_t eff_load;
  pwmg_val_t top_down;
  pwmg_val_t top_ud;
  logic      armed;
  logic      at_zero;
  logic      upd;
  logic      at_top;

  // ============================================================
  // Pending values, applied only at zero
  assign at_zero  = ctl.enable && (count == `PWMG_RST_VAL16);
  assign upd      = at_zero && (!ctl.sync_mode || armed);
  assign eff_load = upd ? load_prog : act_load;
  assign top_down = (eff_load == `PWMG_RST_VAL16) ? eff_load : 16'(eff_load - 16'h0001);
  assign top_ud   = eff_load >> 1;
  assign at_top   = (dir == PWMG_DIR_UP) && (count >= top_ud);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      load_prog <= `PWMG_RST_VAL16;
      cmpa_prog <= `PWMG_RST_VAL16;
      cmpb_prog <= `PWMG_RST_VAL16;
    end
    else
    begin
      if (load_wr) load_prog <= wdata;
      if (cmpa_wr) cmpa_prog <= wdata;
      if (cmpb_wr) cmpb_prog <= wdata;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      act_load <= `PWMG_RST_VAL16;
      act_a    <= `PWMG_RST_VAL16;
      act_b    <= `PWMG_RST_VAL16;
    end
    else if (upd)
    begin
      act_load <= load_prog;
      act_a    <= cmpa_prog;
      act_b    <= cmpb_prog;
    end

  // Sync request set wins over its consumption
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      armed <= 1'b0;
    else
      armed <= sync_evt || (armed && !upd);

  // ============================================================
  // Counter; holds while disabled
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      count <= `PWMG_RST_VAL16;
      dir   <= PWMG_DIR_DOWN;
    end
    else if (ctl.enable)
    begin
      if (!ctl.up_down)
      begin
        dir   <= PWMG_DIR_DOWN;
        count <= at_zero ? top_down : 16'(count - 16'h0001);
      end
      else if (at_top)
      begin
        dir   <= PWMG_DIR_DOWN;
        count <= (count == `PWMG_RST_VAL16) ? count : 16'(count - 16'h0001);
      end
      else if (dir == PWMG_DIR_DOWN && at_zero)
      begin
        dir   <= PWMG_DIR_UP;
        count <= (top_ud == `PWMG_RST_VAL16) ? count : 16'h0001;
      end
      else if (dir == PWMG_DIR_UP)
        count <= 16'(count + 16'h0001);
      else
        count <= 16'(count - 16'h0001);
    end

  // ============================================================
  // Event decode
  always_comb
  begin
    evt               = '0;
    evt.count_at_zero = at_zero;
    evt.count_reload  = ctl.enable && (ctl.up_down ? at_top : at_zero);
    evt.cmp_a_up      = ctl.enable && (count == act_a) && (dir == PWMG_DIR_UP);
    evt.cmp_a_down    = ctl.enable && (count == act_a) && (dir == PWMG_DIR_DOWN);
    evt.cmp_b_up      = ctl.enable && (count == act_b) && (dir == PWMG_DIR_UP);
    evt.cmp_b_down    = ctl.enable && (count == act_b) && (dir == PWMG_DIR_DOWN);
  end

endmodule : pwmg_gen

/* pwmg_top.sv */
/*
  APB-reached control of four PWM generators: enables, periods, compare values,
  per-generator interrupt/trigger status and masks, and module-level interrupt enable.
  Assumes a zero-wait APB master on pclk and fault inputs synchronous to pclk.
*/
`timescale 1ns/1ps
`include "pwmg_map.svh"

// Function
// - A disabled generator's counter holds its value.
// - An enabled generator's counter advances every clock while its active period is two or more; each generator enabled independently.
// - Generator status bits clear on writing one; writing zero leaves them.
// - Six events per generator: zero, reload, compare A/B up and down.
// - Software reads raw status or status ANDed with the enables.
// - Setting enable bits unmasks interrupts and passes triggers.
// - Clearing enable bits masks interrupts and suppresses triggers.
// - Clock ticks between successive zero events equal the period, rounded down to even in up/down mode.
// - Period readback returns the last programmed value, even while pending.
// - A newer period write replaces a pending one; last write wins.
// - Module enable register: four generator and four fault bits; clear masks.
// - Module enable governs generator summary and fault interrupts.
// - Setting a module enable bit unmasks that interrupt.
// - New period or width applies at zero; sync mode also waits sync.
// - Counter runs down with reload, or up/down between zero and half the period value.
module pwmg_top
  import pwmg_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  fault_in,
  output logic      [23:0] trig_out,
  output logic             irq
);

  // ============================================================
  // Address decode
  logic       wr_en;
  logic       rd_setup;
  logic       gen_hit;
  logic [2:0] blk;
  logic [1:0] gidx;
  logic [5:0] goff;
  logic       addr_ok;

  assign wr_en    = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign blk      = paddr[8:6];
  assign goff     = paddr[5:0];
  assign gen_hit  = (paddr[11:9] == 3'h0) && (blk >= `PWMG_BLK_FIRST) && (blk <= `PWMG_BLK_LAST);
  assign gidx     = 2'(blk - `PWMG_BLK_FIRST);

  always_comb
  begin
    if (gen_hit)
      addr_ok = (goff[1:0] == 2'h0) && (goff <= `PWMG_OFF_GEN_ISC);
    else if (paddr == `PWMG_OFF_SYNC)
      addr_ok = 1'b1;
    else if (paddr == `PWMG_OFF_MOD_INTEN)
      addr_ok = 1'b1;
    else if (paddr == `PWMG_OFF_MOD_RIS)
      addr_ok = 1'b1;
    else if (paddr == `PWMG_OFF_MOD_ISC)
      addr_ok = 1'b1;
    else
      addr_ok = 1'b0;
  end

  // ============================================================
  // Per-generator state
  pwmg_ctl_s  gen_ctl   [4];
  logic [13:0] gen_inten [4];
  pwmg_evt_s  gen_ris   [4];
  pwmg_val_t  load_prog [4];
  pwmg_val_t  cmpa_prog [4];
  pwmg_val_t  cmpb_prog [4];
  pwmg_val_t  gen_count [4];
  logic [5:0] gen_mis   [4];
  logic [3:0] gen_sum;
  logic [3:0] sync_evt;

  assign sync_evt = (wr_en && paddr == `PWMG_OFF_SYNC) ? pwdata[3:0] : 4'h0;

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : gen_blk
      logic      sel_wr;
      pwmg_evt_s evt;
      logic [5:0] irq_en;
      logic [5:0] trig_en;

      assign sel_wr  = wr_en && gen_hit && (gidx == 2'(g));
      assign irq_en  = gen_inten[g][5:0];
      assign trig_en = gen_inten[g][`PWMG_TRIG_LSB +: 6];

      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          gen_ctl[g] <= `PWMG_RST_CTL;
        else if (sel_wr && goff == `PWMG_OFF_GEN_CTL)
          gen_ctl[g] <= pwdata[2:0];

      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          gen_inten[g] <= `PWMG_RST_INTEN;
        else if (sel_wr && goff == `PWMG_OFF_GEN_INTEN)
          gen_inten[g] <= {pwdata[13:8], 2'h0, pwdata[5:0]};

      // Hardware set wins over a same-cycle write-one clear
      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          gen_ris[g] <= '0;
        else if (sel_wr && goff == `PWMG_OFF_GEN_ISC)
          gen_ris[g] <= (gen_ris[g] & ~pwdata[5:0]) | evt;
        else
          gen_ris[g] <= gen_ris[g] | evt;

      always_ff @(posedge pclk or negedge presetn)
        if (!presetn)
          trig_out[g*6 +: 6] <= 6'h00;
        else
          trig_out[g*6 +: 6] <= evt & trig_en;

      assign gen_mis[g] = gen_ris[g] & irq_en;
      assign gen_sum[g] = |gen_mis[g];

      pwmg_gen pwmg_gen_i (
        .pclk      (pclk),
        .presetn   (presetn),
        .ctl       (gen_ctl[g]),
        .sync_evt  (sync_evt[g]),
        .load_wr   (sel_wr && goff == `PWMG_OFF_GEN_LOAD),
        .cmpa_wr   (sel_wr && goff == `PWMG_OFF_GEN_CMPA),
        .cmpb_wr   (sel_wr && goff == `PWMG_OFF_GEN_CMPB),
        .wdata     (pwdata[15:0]),
        .load_prog (load_prog[g]),
        .cmpa_prog (cmpa_prog[g]),
        .cmpb_prog (cmpb_prog[g]),
        .count     (gen_count[g]),
        .evt       (evt)
      );
    end
  endgenerate

  // ============================================================
  // Module-level interrupts
  logic [7:0] mod_inten;
  logic [3:0] fault_sts;
  logic [7:0] mod_ris;
  logic [7:0] mod_mis;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mod_inten <= `PWMG_RST_MOD_INTEN;
    else if (wr_en && paddr == `PWMG_OFF_MOD_INTEN)
      mod_inten <= pwdata[7:0];

  // Fault level set wins over a same-cycle clear
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      fault_sts <= 4'h0;
    else if (wr_en && paddr == `PWMG_OFF_MOD_ISC)
      fault_sts <= (fault_sts & ~pwdata[`PWMG_FAULT_LSB +: 4]) | fault_in;
    else
      fault_sts <= fault_sts | fault_in;

  assign mod_ris = {fault_sts, gen_sum};
  assign mod_mis = mod_ris & mod_inten;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |mod_mis;

  // ============================================================
  // Read data, captured in the setup phase
  logic [31:0] rd_val;

  always_comb
  begin
    rd_val = 32'h0000_0000;
    if (gen_hit)
    begin
      if (goff == `PWMG_OFF_GEN_CTL)
        rd_val = {29'h0, gen_ctl[gidx]};
      else if (goff == `PWMG_OFF_GEN_LOAD)
        rd_val = {16'h0, load_prog[gidx]};
      else if (goff == `PWMG_OFF_GEN_COUNT)
        rd_val = {16'h0, gen_count[gidx]};
      else if (goff == `PWMG_OFF_GEN_CMPA)
        rd_val = {16'h0, cmpa_prog[gidx]};
      else if (goff == `PWMG_OFF_GEN_CMPB)
        rd_val = {16'h0, cmpb_prog[gidx]};
      else if (goff == `PWMG_OFF_GEN_INTEN)
        rd_val = {18'h0, gen_inten[gidx]};
      else if (goff == `PWMG_OFF_GEN_RIS)
        rd_val = {26'h0, gen_ris[gidx]};
      else if (goff == `PWMG_OFF_GEN_ISC)
        rd_val = {26'h0, gen_mis[gidx]};
    end
    else if (paddr == `PWMG_OFF_MOD_INTEN)
      rd_val = {24'h0, mod_inten};
    else if (paddr == `PWMG_OFF_MOD_RIS)
      rd_val = {24'h0, mod_ris};
    else if (paddr == `PWMG_OFF_MOD_ISC)
      rd_val = {24'h0, mod_mis};
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata <= 32'h0000_0000;
    else if (rd_setup && !pwrite)
      prdata <= rd_val;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      pslverr <= 1'b0;
    else if (rd_setup)
      pslverr <= !addr_ok;

  // Zero-wait slave
  assign pready = 1'b1;

endmodule : pwmg_top

/* pwmg_top_asserts.sv */
/*
  Port-level checker of the four-generator PWM control block.
  Assumes it is bound to pwmg_top and sees only its ports.
*/
`timescale 1ns/1ps
`include "pwmg_map.svh"

module pwmg_top_asserts
  import pwmg_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [3:0]  fault_in,
  input wire logic [23:0] trig_out,
  input wire logic        irq
);
  logic [23:0] trig_en;
  logic [7:0]  mod_en;
  wire         mapped = paddr[11:9] == 3'h0 && paddr[1:0] == 2'h0 &&
                        (paddr[8:6] == 3'h0 ? paddr[5:4] == 2'h0 : paddr[8:6] <= 3'h4 && !paddr[5]);

  // ============================================================
  // Shadow of enables written by software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trig_en <= 24'h000000;
      mod_en  <= 8'h00;
    end
    else if (psel && penable && pwrite)
    begin
      if (paddr == `PWMG_OFF_MOD_INTEN)
        mod_en <= pwdata[7:0];
      for (int g = 0; g < 4; g++)
        if (paddr == {3'h0, 3'(g + 1), `PWMG_OFF_GEN_INTEN})
          trig_en[g*6 +: 6] <= pwdata[13:8];
    end
  end

  // ============================================================
  // Properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_fault_on;
    fault_in != 4'h0 ##1 ($past(fault_in) & mod_en[7:4]) != 4'h0;
  endsequence

  AST_PREADY: assert property (s_acc |-> pready) else $error("pready low in access");
  AST_MAPPED_OK: assert property (s_acc ##0 mapped |-> !pslverr)
    else $error("error on mapped address");
  AST_UNMAPPED_ERR: assert property (s_acc ##0 paddr[8:6] > 3'h4 |-> pslverr)
    else $error("no error on unmapped address");
  AST_SYNC_RD0: assert property (s_acc ##0 !pwrite && paddr == `PWMG_OFF_SYNC |-> prdata == 32'h0)
    else $error("sync register read not zero");
  AST_TRIG_MASK: assert property ((trig_out & ~(trig_en | $past(trig_en))) == 24'h0)
    else $error("trigger pulse while disabled");
  AST_IRQ_MASK: assert property ((mod_en | $past(mod_en)) == 8'h0 |-> !irq)
    else $error("irq with all sources masked");
  AST_FAULT_IRQ: assert property (s_fault_on |-> ##1 irq)
    else $error("enabled fault gave no irq");
  AST_IRQ_RST: assert property ($rose(presetn) |-> !irq)
    else $error("irq high after reset");

endmodule : pwmg_top_asserts

bind pwmg_top pwmg_top_asserts pwmg_top_asserts_i (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .fault_in, .trig_out, .irq);

/* pwmg_tb.sv */
/*
  Self-checking bench of the PWM control block, driven over APB.
  Assumes pwmg_top and the offsets of the map header.
*/
`timescale 1ns/1ps
`include "pwmg_map.svh"

module tb_top
  import pwmg_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        err;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] rd2;
  logic [3:0]  fault_in;
  logic [23:0] trig_out;
  int          fails;
  int          n_tests;
  int          cyc;
  int          gap;

  pwmg_top pwmg_top_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
                       .pready, .pslverr, .fault_in, .trig_out, .irq);

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ============================================================
  // Bus and check tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    check(name, rd, exp);
  endtask : rc

  function automatic logic [11:0] ga(input int g, input logic [5:0] off);
    return {3'h0, 3'(g + 1), off};
  endfunction : ga

  // Cycles between trigger pulses, the last of three gaps
  task automatic period(input int b, output int n);
    for (int k = 0; k < 3; k++)
    begin
      n = 0;
      do
      begin
        @(posedge pclk);
        #1 n++;
      end
      while (trig_out[b] !== 1'b1 && n < 200);
    end
  endtask : period

  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle

  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      give_verdict();
    end
  end

  // ============================================================
  // Main sequence
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    fault_in = 4'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    for (int g = 0; g < 4; g++)
    begin
      rc(ga(g, `PWMG_OFF_GEN_CTL), 32'h0, "ctl");
      rc(ga(g, `PWMG_OFF_GEN_INTEN), 32'h0, "inten");
    end
    rc(`PWMG_OFF_MOD_INTEN, 32'h0, "mod_inten");
    rc(`PWMG_OFF_SYNC, 32'h0, "sync");
    rc(12'hffc, 32'h0, "unmapped");
    check("slverr", err, 32'h1);
    // Run and hold of one generator
    apb(1'b1, ga(0, `PWMG_OFF_GEN_LOAD), 32'h10);
    apb(1'b1, ga(0, `PWMG_OFF_GEN_CTL), 32'h1);
    apb(1'b0, ga(0, `PWMG_OFF_GEN_COUNT), 32'h0);
    rd2 = rd;
    rc(ga(3, `PWMG_OFF_GEN_COUNT), 32'h0, "idle count");
    apb(1'b0, ga(0, `PWMG_OFF_GEN_COUNT), 32'h0);
    check("running", 32'(rd !== rd2), 32'h1);
    apb(1'b1, ga(0, `PWMG_OFF_GEN_CTL), 32'h0);
    apb(1'b0, ga(0, `PWMG_OFF_GEN_COUNT), 32'h0);
    rd2 = rd;
    repeat (7) @(posedge pclk);
    rc(ga(0, `PWMG_OFF_GEN_COUNT), rd2, "held count");
    // Pending period, both counting modes, all six events
    apb(1'b1, ga(2, `PWMG_OFF_GEN_LOAD), 32'h5);
    apb(1'b1, ga(2, `PWMG_OFF_GEN_LOAD), 32'h8);
    rc(ga(2, `PWMG_OFF_GEN_LOAD), 32'h8, "load");
    apb(1'b1, ga(2, `PWMG_OFF_GEN_CMPA), 32'h1);
    apb(1'b1, ga(2, `PWMG_OFF_GEN_CMPB), 32'h2);
    apb(1'b1, ga(2, `PWMG_OFF_GEN_INTEN), 32'h100);
    for (int m = 0; m < 2; m++)
    begin
      apb(1'b1, ga(2, `PWMG_OFF_GEN_CTL), 32'(1 + 2 * m));
      period(12, gap);
      check("period", 32'(gap), 32'h8);
    end
    apb(1'b1, ga(2, `PWMG_OFF_GEN_CTL), 32'h0);
    rc(ga(2, `PWMG_OFF_GEN_RIS), 32'h3f, "events");
    // Sync mode holds a new period until a sync request
    apb(1'b1, ga(1, `PWMG_OFF_GEN_LOAD), 32'h4);
    apb(1'b1, ga(1, `PWMG_OFF_GEN_INTEN), 32'h100);
    apb(1'b1, ga(1, `PWMG_OFF_GEN_CTL), 32'h5);
    period(6, gap);
    check("no sync", 32'(gap), 32'h1);
    apb(1'b1, `PWMG_OFF_SYNC, 32'h2);
    period(6, gap);
    check("synced", 32'(gap), 32'h4);
    apb(1'b1, ga(1, `PWMG_OFF_GEN_CTL), 32'h0);
    // Masks and clearing of generator status
    apb(1'b1, ga(2, `PWMG_OFF_GEN_INTEN), 32'h0);
    rc(ga(2, `PWMG_OFF_GEN_ISC), 32'h0, "masked off");
    apb(1'b1, ga(2, `PWMG_OFF_GEN_INTEN), 32'h5);
    rc(ga(2, `PWMG_OFF_GEN_ISC), 32'h5, "masked on");
    apb(1'b1, ga(2, `PWMG_OFF_GEN_ISC), 32'h0);
    rc(ga(2, `PWMG_OFF_GEN_RIS), 32'h3f, "w0 keeps");
    apb(1'b1, ga(2, `PWMG_OFF_GEN_ISC), 32'h1);
    rc(ga(2, `PWMG_OFF_GEN_RIS), 32'h3e, "w1 clears");
    // Module summary, enable and interrupt output
    rc(`PWMG_OFF_MOD_RIS, 32'h4, "summary");
    check("irq masked", irq, 32'h0);
    apb(1'b1, `PWMG_OFF_MOD_INTEN, 32'h4);
    settle();
    check("irq on", irq, 32'h1);
    rc(`PWMG_OFF_MOD_ISC, 32'h4, "mod masked");
    apb(1'b1, ga(2, `PWMG_OFF_GEN_ISC), 32'h4);
    settle();
    check("irq cleared", irq, 32'h0);
    rc(`PWMG_OFF_MOD_RIS, 32'h0, "summary off");
    // Fault interrupts
    apb(1'b1, `PWMG_OFF_MOD_INTEN, 32'hf0);
    @(posedge pclk);
    fault_in <= 4'hf;
    @(posedge pclk);
    fault_in <= 4'h0;
    settle();
    check("fault irq", irq, 32'h1);
    rc(`PWMG_OFF_MOD_RIS, 32'hf0, "faults");
    apb(1'b1, `PWMG_OFF_MOD_ISC, 32'h30);
    rc(`PWMG_OFF_MOD_RIS, 32'hc0, "fault clear");
    apb(1'b1, `PWMG_OFF_MOD_INTEN, 32'h30);
    settle();
    check("fault masked", irq, 32'h0);
    give_verdict();
  end

endmodule : tb_top
